// ==== src/pdw_pkg.sv ====
// Package with register offsets, field positions, reset values and timing.
package pdw_pkg;
    // Register offsets on the plain register port.
    localparam logic [2:0] ADDR_WDOG_CTRL = 3'h0;
    localparam logic [2:0] ADDR_PWR_FLAGS = 3'h1;
    localparam logic [2:0] ADDR_SYS_MODE = 3'h2;
    localparam logic [2:0] ADDR_STATUS = 3'h3;
    localparam logic [2:0] ADDR_WAKE_EN = 3'h4;
    // Reset values.
    localparam logic [7:0] WDOG_CTRL_RST = 8'h53;
    localparam logic [7:0] SYS_MODE_RST = 8'hc2;
    // Enable key values and field positions.
    localparam logic [4:0] WDOG_KEY_A = 5'h0a;
    localparam logic [4:0] WDOG_KEY_B = 5'h15;
    localparam int KEY_LSB = 3;
    localparam int IDLE_EN_BIT = 1;
    localparam int HICLK_BIT = 0;
    localparam int KEEP_ON_BIT = 7;
    // Bad key reset fires on the slow clock edge after the delay count reaches this value (2~3 window).
    localparam logic [1:0] KEY_RESET_DELAY = 2'h2;
    // Slow clock 32 kHz derived from 25 MHz master clock.
    localparam int MCLK_HZ = 25000000;
    localparam int SLOW_HZ = 32000;
    localparam int SLOW_DIV = MCLK_HZ / SLOW_HZ;
    // Power state of the device.
    typedef enum logic [1:0] {PDW_RUN, PDW_SLEEP, PDW_IDLE0, PDW_IDLE1}
        pdw_mode_t;
endpackage : pdw_pkg

// ==== src/pdw_wdog_counter.sv ====
// Watchdog counter with selectable overflow tap.
`timescale 1ns/1ps
module pdw_wdog_counter
    import pdw_pkg::*;
#(
    parameter int WIDTH = 18
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic resetn,
    // Control.
    input wire logic tick,
    input wire logic clear,
    input wire logic [2:0] periodSel,
    // Status.
    output logic overflow
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic ovf;
    } pdw_cnt_t;
    pdw_cnt_t st_r;
    pdw_cnt_t st_nxt;
    logic [WIDTH-1:0] lastVal;

    // Tap value for the selected period minus one.
    always_comb begin
        case (periodSel)
            3'h0: lastVal = WIDTH'((1 << 8) - 1);
            3'h1: lastVal = WIDTH'((1 << 10) - 1);
            3'h2: lastVal = WIDTH'((1 << 12) - 1);
            3'h3: lastVal = WIDTH'((1 << 14) - 1);
            3'h4: lastVal = WIDTH'((1 << 15) - 1);
            3'h5: lastVal = WIDTH'((1 << 16) - 1);
            3'h6: lastVal = WIDTH'((1 << 17) - 1);
            default: lastVal = WIDTH'((1 << 18) - 1);
        endcase
    end

    // Count slow ticks, pulse overflow at the selected period.
    always_comb begin
        st_nxt = st_r;
        st_nxt.ovf = 1'b0;
        if (clear) begin
            st_nxt.count = '0;
        end else if (tick) begin
            if (st_r.count >= lastVal) begin
                st_nxt.count = '0;
                st_nxt.ovf = 1'b1;
            end else begin
                st_nxt.count = st_r.count + 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign overflow = st_r.ovf;
endmodule : pdw_wdog_counter

// ==== src/pdw_power_watchdog.sv ====
// Power-down mode control and watchdog timer.
// Overview of operation
// - High clock select or divider 010..111 returns system to fast clock.
// - Halt with idle enable 0 enters sleep; system and timebase stop.
// - Halt with idle, keep-on 0 enters idle0; timebase and slow run.
// - Halt with idle, keep-on 1 enters idle1; all clocks run, CPU stops.
// - Power-down keeps memory, registers and ports unchanged.
// - Halt entry clears the watchdog counter which keeps counting.
// - Halt entry sets power-down flag and clears timeout flag.
// - Wake on port A falling edge, interrupt or watchdog overflow.
// - Overflow in power-down sets timeout, wakes, resets PC and SP only.
// - Power-down flag cleared at power-up or clear, set on halt.
// - Per-pin port A wake enable; resume after the halt.
// - Disabled interrupt or full stack: resume after halt, keep pending.
// - Enabled interrupt with free stack: take interrupt on wake.
// - Interrupt already pending at halt does not wake that period.
// - Watchdog periods 2^8..2^18 slow clocks by period select code.
// - Reset loads watchdog control 0x53 except power-down overflow.
// - Watchdog runs when enable key is 01010 or 10101.
// - Other key resets device 2~3 slow clocks later, sets reset flag.
// - Watchdog register reset flag cleared only by software writing 0.
// - Counter overflow resets device unless cleared beforehand.
// - Flags register: bit 7 keep-on, bits 6..3 zero, 2..0 reset flags.
// - Overflow while running sets timeout and does a full reset.
// - Slow clock keeps running in sleep so the watchdog counts.
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module pdw_power_watchdog
    import pdw_pkg::*;
#(
    parameter int PORTA_WIDTH = 8,
    parameter int SLOW_DIVIDE = SLOW_DIV
) (
    // Clock and power-on reset.
    input wire logic mclk,
    input wire logic resetn,
    // Register port.
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    // CPU core events.
    input wire logic haltExec,
    input wire logic wdogClearExec,
    input wire logic [PORTA_WIDTH-1:0] portaIn,
    input wire logic [PORTA_WIDTH-1:0] portaWakeEn,
    input wire logic irqRequest,
    input wire logic irqEnabled,
    input wire logic stackFull,
    input wire logic fastOscStable,
    input wire logic lowVoltReset,
    input wire logic lowVoltRegReset,
    // Clock gating and status outputs.
    output logic sysClockEn,
    output logic timebaseClockEn,
    output logic slowClockEn,
    output logic highSpeedSel,
    output logic cpuRun,
    output logic wakeTakeIrq,
    output logic wakeResumeNext,
    output logic pcSpReset,
    output logic deviceResetn,
    output logic powerDownFlag,
    output logic timeoutFlag
);
    typedef struct packed {
        pdw_mode_t mode;
        logic [7:0] wdogCtrl;
        logic [7:0] sysMode;
        logic keepOn;
        logic lvrFlag;
        logic lrfFlag;
        logic wrfFlag;
        logic power_down_flag;
        logic to;
        logic [PORTA_WIDTH-1:0] portaPrev;
        logic irqPrev;
        logic irqMasked;
        logic [15:0] divCnt;
        logic [1:0] keyDelay;
        logic keyBad;
        logic devReset;
        logic [7:0] rdata;
        logic takeIrq;
        logic resumeNext;
        logic pcSp;
    } pdw_state_t;

    pdw_state_t st_r;
    pdw_state_t st_nxt;
    logic slowTick;
    logic wdogOverflow;
    logic wdogClear;
    logic keyOk;
    logic [PORTA_WIDTH-1:0] fallEdge;
    logic portWake;
    logic irqWake;
    logic inPowerDown;

    // Decode of the enable key and power-down state.
    assign keyOk = (st_r.wdogCtrl[7:KEY_LSB] == WDOG_KEY_A) ||
                   (st_r.wdogCtrl[7:KEY_LSB] == WDOG_KEY_B);
    assign inPowerDown = (st_r.mode != PDW_RUN);
    assign slowTick = (st_r.divCnt == 16'(SLOW_DIVIDE - 1));
    assign fallEdge = st_r.portaPrev & ~portaIn & portaWakeEn;
    assign portWake = |fallEdge;
    // Only a fresh request wakes the device, not one pending at halt.
    assign irqWake = irqRequest & ~st_r.irqMasked;
    assign wdogClear = wdogClearExec | (haltExec && !inPowerDown);

    // Watchdog counter running from the slow tick.
    pdw_wdog_counter #(
        .WIDTH(18)
    ) u_counter (
        .mclk(mclk),
        .resetn(resetn && st_r.devReset == 1'b0),
        .tick(slowTick && keyOk),
        .clear(wdogClear),
        .periodSel(st_r.wdogCtrl[2:0]),
        .overflow(wdogOverflow)
    );

    // Next-state logic for mode, registers, flags and reset sequencing.
    always_comb begin
        st_nxt = st_r;
        st_nxt.takeIrq = 1'b0;
        st_nxt.resumeNext = 1'b0;
        st_nxt.pcSp = 1'b0;
        st_nxt.devReset = 1'b0;
        st_nxt.portaPrev = portaIn;
        st_nxt.irqPrev = irqRequest;
        // Slow clock divider keeps running in every mode.
        if (slowTick) begin
            st_nxt.divCnt = '0;
        end else begin
            st_nxt.divCnt = st_r.divCnt + 16'h0001;
        end
        // Register writes; the reset flags only clear by writing 0.
        if (regWr) begin
            case (regAddr)
                ADDR_WDOG_CTRL: st_nxt.wdogCtrl = regWdata;
                ADDR_PWR_FLAGS: begin
                    st_nxt.keepOn = regWdata[KEEP_ON_BIT];
                    st_nxt.lvrFlag = st_r.lvrFlag & regWdata[2];
                    st_nxt.lrfFlag = st_r.lrfFlag & regWdata[1];
                    st_nxt.wrfFlag = st_r.wrfFlag & regWdata[0];
                end
                ADDR_SYS_MODE: st_nxt.sysMode = regWdata;
                default: ;
            endcase
        end
        // Hardware sets of the low-voltage flags win over a clear.
        if (lowVoltReset) begin
            st_nxt.lvrFlag = 1'b1;
        end
        if (lowVoltRegReset) begin
            st_nxt.lrfFlag = 1'b1;
        end
        // Bad key: reset after 2~3 slow clock edges.
        if (!keyOk) begin
            if (slowTick) begin
                if (st_r.keyDelay == KEY_RESET_DELAY) begin
                    st_nxt.devReset = 1'b1;
                    st_nxt.keyDelay = '0;
                end else begin
                    st_nxt.keyDelay = st_r.keyDelay + 2'h1;
                end
            end
        end else begin
            st_nxt.keyDelay = '0;
        end
        // Clear instruction clears power-down flag.
        if (wdogClearExec) begin
            st_nxt.power_down_flag = 1'b0;
        end
        // Halt entry picks the power-down mode.
        if (haltExec && !inPowerDown) begin
            if (!st_r.sysMode[IDLE_EN_BIT]) begin
                st_nxt.mode = PDW_SLEEP;
            end else if (!st_r.keepOn) begin
                st_nxt.mode = PDW_IDLE0;
            end else begin
                st_nxt.mode = PDW_IDLE1;
            end
            st_nxt.power_down_flag = 1'b1;
            st_nxt.to = 1'b0;
            st_nxt.irqMasked = irqRequest;
        end
        // Wake-up handling in power-down; register contents untouched.
        if (inPowerDown) begin
            if (wdogOverflow) begin
                st_nxt.mode = PDW_RUN;
                st_nxt.to = 1'b1;
                st_nxt.pcSp = 1'b1;
            end else if (portWake) begin
                st_nxt.mode = PDW_RUN;
                st_nxt.resumeNext = 1'b1;
            end else if (irqWake) begin
                st_nxt.mode = PDW_RUN;
                if (irqEnabled && !stackFull) begin
                    st_nxt.takeIrq = 1'b1;
                end else begin
                    st_nxt.resumeNext = 1'b1;
                end
            end
        end else if (wdogOverflow) begin
            st_nxt.to = 1'b1;
            st_nxt.devReset = 1'b1;
        end
        if (!irqRequest) begin
            st_nxt.irqMasked = 1'b0;
        end
        // Full device reset reinitialises, keeping flags that survive.
        if (st_r.devReset) begin
            st_nxt.wdogCtrl = WDOG_CTRL_RST;
            st_nxt.mode = PDW_RUN;
            st_nxt.keyDelay = '0;
        end
        if (st_nxt.devReset && !keyOk) begin
            st_nxt.wrfFlag = 1'b1;
        end
        // Read data stand one cycle after the read strobe.
        st_nxt.rdata = '0;
        if (regRd) begin
            case (regAddr)
                ADDR_WDOG_CTRL: st_nxt.rdata = st_r.wdogCtrl;
                ADDR_PWR_FLAGS: st_nxt.rdata = {st_r.keepOn, 4'h0,
                    st_r.lvrFlag, st_r.lrfFlag, st_r.wrfFlag};
                ADDR_SYS_MODE: st_nxt.rdata = {st_r.sysMode[7:4],
                    1'b0, fastOscStable, st_r.sysMode[1:0]};
                ADDR_STATUS: st_nxt.rdata = {4'h0, st_r.mode,
                    st_r.power_down_flag, st_r.to};
                default: st_nxt.rdata = '0;
            endcase
        end
    end

    // State register with power-on reset values.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st_r <= '0;
            st_r.mode <= PDW_RUN;
            st_r.wdogCtrl <= WDOG_CTRL_RST;
            st_r.sysMode <= SYS_MODE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Clock gating outputs follow the power mode; state is held.
    always_comb begin
        sysClockEn = (st_r.mode == PDW_RUN) || (st_r.mode == PDW_IDLE1);
        timebaseClockEn = (st_r.mode != PDW_SLEEP);
        slowClockEn = 1'b1;
        cpuRun = (st_r.mode == PDW_RUN);
        // Divider code 010..111 or high select picks the fast source.
        highSpeedSel = st_r.sysMode[HICLK_BIT] ||
                       (st_r.sysMode[7:5] >= 3'h2);
    end

    // Remaining status outputs.
    assign regRdata = st_r.rdata;
    assign wakeTakeIrq = st_r.takeIrq;
    assign wakeResumeNext = st_r.resumeNext;
    assign pcSpReset = st_r.pcSp;
    assign deviceResetn = ~st_r.devReset;
    assign powerDownFlag = st_r.power_down_flag;
    assign timeoutFlag = st_r.to;
endmodule : pdw_power_watchdog

// ==== testbench/pdw_power_watchdog_monitor.sv ====
// Checker of the power-down and watchdog block ports.
`timescale 1ns/1ps
module pdw_power_watchdog_monitor
    import pdw_pkg::*;
(
    // Clock, reset and register read port.
    input wire logic mclk, resetn, regRd,
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regRdata,
    // Core events and power state.
    input wire logic haltExec, wdogClearExec, irqEnabled, stackFull,
    input wire logic sysClockEn, timebaseClockEn, slowClockEn, cpuRun,
    input wire logic wakeTakeIrq, wakeResumeNext, powerDownFlag
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // A halt accepted while the core runs.
    sequence s_halt;
        haltExec && cpuRun;
    endsequence
    // A clear instruction executed on its own.
    sequence s_clear;
        wdogClearExec && cpuRun && !haltExec;
    endsequence
    // A stopped core with the time base gated off.
    sequence s_sleep;
        !cpuRun && !timebaseClockEn;
    endsequence
    a_halt_flags: assert property (s_halt |=> powerDownFlag)
        else $error("halt left the power-down flag low");
    a_halt_stop: assert property (s_halt |=> !cpuRun)
        else $error("halt did not stop the core");
    a_sleep_gate: assert property (s_sleep |-> !sysClockEn)
        else $error("system clock runs in sleep");
    a_slow_free: assert property (slowClockEn)
        else $error("slow clock stopped");
    a_pdf_clear: assert property (s_clear |=> !powerDownFlag)
        else $error("clear left the power-down flag set");
    a_wake_resume: assert property (
        wakeResumeNext |-> cpuRun && !$past(cpuRun))
        else $error("resume pulse without a wake");
    a_take_irq: assert property (
        wakeTakeIrq |-> $past(irqEnabled) && !$past(stackFull))
        else $error("interrupt taken while it cannot be");
    a_flags_zero: assert property (
        regRd && regAddr == ADDR_PWR_FLAGS |=> regRdata[6:3] == 4'h0)
        else $error("unused flag bits read nonzero");
endmodule : pdw_power_watchdog_monitor

// ==== testbench/pdw_cpu_model.sv ====
// Core model that issues halt and watchdog clear instructions.
`timescale 1ns/1ps
module pdw_cpu_model (
    // Clock and reset.
    input wire logic mclk,
    input wire logic resetn,
    // Bench commands and core state.
    input wire logic doHalt,
    input wire logic clearOn,
    input wire logic cpuRun,
    // Instruction events.
    output logic haltExec,
    output logic wdogClearExec
);
    logic [7:0] tick_r;
    // A stopped core executes nothing, so both events wait for cpuRun.
    always_ff @(posedge mclk) begin
        tick_r <= resetn ? tick_r + 8'h01 : 8'h00;
        haltExec <= resetn && doHalt && cpuRun;
        wdogClearExec <= resetn && clearOn && cpuRun && tick_r == 8'hff;
    end
endmodule : pdw_cpu_model

// ==== testbench/test_pdw_power_watchdog.sv ====
// Self-checking bench of the power-down and watchdog block.
`timescale 1ns/1ps
module test_pdw_power_watchdog import pdw_pkg::*; ();
    logic mclk = 1'b0, resetn = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWdata = 8'h00, portaIn = 8'hff, portaWakeEn = 8'h00;
    logic [7:0] regRdata, rv;
    logic irqRequest = 1'b0, irqEnabled = 1'b0, stackFull = 1'b0;
    logic doHalt = 1'b0, clearOn = 1'b0, haltExec, wdogClearExec;
    logic fastOscStable = 1'b0;
    logic sysClockEn, timebaseClockEn, slowClockEn, highSpeedSel, cpuRun;
    logic wakeTakeIrq, wakeResumeNext, pcSpReset, deviceResetn;
    logic powerDownFlag, timeoutFlag;
    int num_errors = 0, samples_checked = 0;
    // Clock and the block with a short slow-clock divider.
    always #20 mclk = ~mclk;
    pdw_power_watchdog #(.SLOW_DIVIDE(4)) i_pdw_power_watchdog (
        .mclk, .resetn, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
        .haltExec, .wdogClearExec, .portaIn, .portaWakeEn, .irqRequest,
        .irqEnabled, .stackFull, .fastOscStable,
        .lowVoltReset(1'b0), .lowVoltRegReset(1'b0), .sysClockEn,
        .timebaseClockEn, .slowClockEn, .highSpeedSel, .cpuRun,
        .wakeTakeIrq, .wakeResumeNext, .pcSpReset, .deviceResetn,
        .powerDownFlag, .timeoutFlag);
    pdw_cpu_model i_pdw_cpu_model (.mclk, .resetn, .doHalt, .clearOn,
        .cpuRun, .haltExec, .wdogClearExec);
    // Reporting, comparison and bus helpers.
    task automatic err(input string m);
        num_errors++;
        $display("Error at %0t: %s", $time, m);
    endtask : err
    task automatic chk1(input logic g, input logic e, input string m);
        samples_checked++;
        if (g !== e) err(m);
    endtask : chk1
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] e,
        input logic [7:0] msk = 8'hff);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 rv = regRdata & msk;
        samples_checked++;
        if (rv !== e) err("read");
    endtask : rd
    task automatic halt();
        @(posedge mclk);
        doHalt <= 1'b1;
        @(posedge mclk);
        doHalt <= 1'b0;
        @(posedge mclk);
        #1;
    endtask : halt
    function automatic logic sel(input int k);
        case (k)
            0: return cpuRun;
            1: return !deviceResetn;
            2: return wakeTakeIrq;
            3: return wakeResumeNext;
            default: return pcSpReset;
        endcase
    endfunction : sel
    // Waits a bounded time for one event and checks that it came.
    task automatic waitk(input int k, input int lim);
        int n;
        n = 0;
        while (sel(k) !== 1'b1 && n < lim) begin
            @(posedge mclk);
            #1 n++;
        end
        chk1(sel(k), 1'b1, "event");
    endtask : waitk
    // Scenarios.
    task automatic t_regs();
        int d;
        rd(ADDR_WDOG_CTRL, WDOG_CTRL_RST);
        rd(ADDR_PWR_FLAGS, 8'h00);
        rd(3'h5, 8'h00);
        for (d = 0; d < 9; d++) begin
            wr(ADDR_SYS_MODE, d < 8 ? {3'(d), 5'h00} : 8'h01);
            #1 chk1(highSpeedSel, d > 1, "clock");
        end
        // Software polls the fast oscillator ready bit before trusting it.
        rd(ADDR_SYS_MODE, 8'h01);
        fastOscStable <= 1'b1;
        rd(ADDR_SYS_MODE, 8'h05);
        fastOscStable <= 1'b0;
        $display("regs done");
    endtask : t_regs
    task automatic t_sleep();
        wr(ADDR_SYS_MODE, 8'hc0);
        portaWakeEn <= 8'h02;
        halt();
        chk1(cpuRun, 1'b0, "run");
        chk1(sysClockEn | timebaseClockEn, 1'b0, "gate");
        chk1(powerDownFlag & ~timeoutFlag, 1'b1, "flags");
        @(posedge mclk);
        portaIn <= 8'hfe;
        repeat (8) @(posedge mclk);
        portaIn <= 8'hfc;
        #1 chk1(cpuRun, 1'b0, "pin0");
        waitk(3, 6);
        rd(ADDR_SYS_MODE, 8'hc0);
        portaIn <= 8'hff;
        $display("sleep done");
    endtask : t_sleep
    task automatic t_idle();
        int k;
        for (k = 0; k < 2; k++) begin
            wr(ADDR_PWR_FLAGS, k ? 8'h80 : 8'h00);
            wr(ADDR_SYS_MODE, 8'hc2);
            halt();
            chk1(sysClockEn, k[0], "sys");
            chk1(timebaseClockEn & ~cpuRun, 1'b1, "tb");
            @(posedge mclk);
            irqEnabled <= 1'b1;
            stackFull <= k[0];
            irqRequest <= 1'b1;
            waitk(k ? 3 : 2, 6);
            @(posedge mclk);
            irqRequest <= 1'b0;
        end
        $display("idle done");
    endtask : t_idle
    task automatic t_pend();
        wr(ADDR_WDOG_CTRL, 8'h50);
        wr(ADDR_SYS_MODE, 8'hc0);
        stackFull <= 1'b0;
        irqRequest <= 1'b1;
        halt();
        repeat (900) @(posedge mclk);
        #1 chk1(cpuRun, 1'b0, "pend");
        waitk(4, 400);
        chk1(timeoutFlag & deviceResetn, 1'b1, "to");
        rd(ADDR_WDOG_CTRL, 8'h50);
        irqRequest <= 1'b0;
        $display("pend done");
    endtask : t_pend
    task automatic t_run();
        logic bad;
        bad = 1'b0;
        wr(ADDR_WDOG_CTRL, 8'h50);
        repeat (1500) begin
            @(posedge mclk);
            #1 bad |= deviceResetn !== 1'b1;
        end
        chk1(bad | powerDownFlag, 1'b0, "clear");
        clearOn <= 1'b0;
        waitk(1, 1300);
        chk1(timeoutFlag, 1'b1, "to");
        rd(ADDR_WDOG_CTRL, WDOG_CTRL_RST);
        clearOn <= 1'b1;
        $display("run done");
    endtask : t_run
    task automatic t_key();
        wr(ADDR_WDOG_CTRL, 8'h03);
        waitk(1, 20);
        rd(ADDR_WDOG_CTRL, WDOG_CTRL_RST);
        repeat (20) @(posedge mclk);
        rd(ADDR_PWR_FLAGS, 8'h01, 8'h01);
        wr(ADDR_PWR_FLAGS, 8'h00);
        rd(ADDR_PWR_FLAGS, 8'h00, 8'h01);
        $display("key done");
    endtask : t_key
    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test
    // Main sequence after eight cycles of reset.
    initial begin
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        clearOn <= 1'b1;
        t_regs();
        t_sleep();
        t_idle();
        t_pend();
        t_run();
        t_key();
        stop_test();
    end
    // Hang guard well beyond the expected run time.
    initial begin
        #1000000;
        err("timeout");
        stop_test();
    end
endmodule : test_pdw_power_watchdog
bind pdw_power_watchdog pdw_power_watchdog_monitor i_mon (.*);
